/* hw/mfb_map.svh */
// Constants of the multi-function memory block: sizes, synchroniser width and reset values.
// Notes on behaviour
// [RULE_01] Separate write and read ports share 16,384 bits.
// [RULE_02] Word width 1 to 32, depth scales.
// [RULE_03] Write inputs always registered on write clock.
// [RULE_04] Read address and data registered or passed.
// [RULE_05] One reset serves write and read registers.
// [RULE_06] Write clock: dedicated or global, optionally inverted.
// [RULE_07] Write enable: dedicated or global 1/2, invertible.
// [RULE_08] Read clock: dedicated or global, optionally inverted.
// [RULE_09] Read enable: dedicated or global 1/2, invertible.
// [RULE_10] Reset is device reset OR local reset.
// [RULE_11] CAM holds 128 ternary entries of 48 bits.
// [RULE_12] Update writes data at supplied entry address.
// [RULE_13] Compare flags match, multi-match, lowest index.
// [RULE_14] Masked update keeps bits whose mask is one.
// [RULE_15] Masked compare ignores bits whose mask is one.
// [RULE_16] Don't-care write stores wildcard bits under mask.
// [RULE_17] CAM inputs registered; outputs registered or passed.
// [RULE_18] Mask enable used unregistered; user holds it stable.
// [RULE_19] CAM inputs share clock/enable; outputs too; one reset.
// [RULE_20] CAM clock and enable sources selectable, invertible.
// [RULE_21] CAM reset is device reset OR routed local.
// [RULE_22] No hit clears match and multi-match flags.
// [RULE_23] Reset clears registers, never the stored array.
`ifndef MFB_MAP_SVH
`define MFB_MAP_SVH
// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define MFB_ARRAY_BITS   16384
`define MFB_SRAM_WORDS   512
`define MFB_SRAM_AW      14
`define MFB_SRAM_DW      32
`define MFB_CAM_ENTRIES  128
`define MFB_CAM_AW       7
`define MFB_CAM_DW       48
// ----------------------------------------------------------------------
// Reset values and synchroniser bit count
// ----------------------------------------------------------------------
`define MFB_SYNC_BITS    12
`define MFB_RD_DATA_RST  32'h0000_0000
`define MFB_CAM_IDX_RST  7'h00
`endif

/* hw/mfb_pkg.sv */
// Types shared by the multi-function memory block.
package mfb_pkg;
	// Clock source: dedicated pin or one of four global clocks.
	typedef enum logic [2:0] {
		CLK_DEDICATED = 3'h0,
		CLK_GLOBAL_0  = 3'h1,
		CLK_GLOBAL_1  = 3'h2,
		CLK_GLOBAL_2  = 3'h3,
		CLK_GLOBAL_3  = 3'h4
	} clk_src_t;
	// Clock enable source: dedicated pin or global clock one or two.
	typedef enum logic [1:0] {
		CE_DEDICATED = 2'h0,
		CE_GLOBAL_1  = 2'h1,
		CE_GLOBAL_2  = 2'h2
	} ce_src_t;
	// Data width of the dual-port memory, as log2 of the bit count.
	typedef enum logic [2:0] {
		WIDTH_1 = 3'h0, WIDTH_2 = 3'h1, WIDTH_4 = 3'h2,
		WIDTH_8 = 3'h3, WIDTH_16 = 3'h4, WIDTH_32 = 3'h5
	} width_t;
endpackage : mfb_pkg

/* hw/multi_function_block.sv */
// Multi-function block memory: pseudo dual-port SRAM and ternary CAM modes.
`timescale 1ns/100ps
`include "mfb_map.svh"
module multi_function_block import mfb_pkg::*; (
	// System clock and reset.
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	// Mode and configuration.
	input  wire logic                     cam_mode,
	input  wire width_t                   width_sel,
	input  wire clk_src_t                 wclk_src,
	input  wire logic                     wclk_inv,
	input  wire ce_src_t                  wce_src,
	input  wire logic                     wce_inv,
	input  wire clk_src_t                 rclk_src,
	input  wire logic                     rclk_inv,
	input  wire ce_src_t                  rce_src,
	input  wire logic                     rce_inv,
	input  wire clk_src_t                 cclk_src,
	input  wire logic                     cclk_inv,
	input  wire ce_src_t                  cce_src,
	input  wire logic                     cce_inv,
	input  wire logic                     sram_reset_inv,
	input  wire logic                     cam_reset_inv,
	input  wire logic                     rd_addr_registered,
	input  wire logic                     rd_data_registered,
	input  wire logic                     cam_out_registered,
	// Clock, enable and reset pins.
	input  wire logic                     global_clock_0,
	input  wire logic                     global_clock_1,
	input  wire logic                     global_clock_2,
	input  wire logic                     global_clock_3,
	input  wire logic                     write_clock,
	input  wire logic                     read_clock,
	input  wire logic                     cam_clock,
	input  wire logic                     write_port_clock_enable,
	input  wire logic                     read_port_clock_enable,
	input  wire logic                     cam_clock_enable,
	input  wire logic                     sram_local_reset,
	input  wire logic                     cam_local_reset,
	// Dual-port memory user side.
	input  wire logic [`MFB_SRAM_AW-1:0]  wr_addr,
	input  wire logic [`MFB_SRAM_DW-1:0]  wr_data,
	input  wire logic                     wr_chip_sel,
	input  wire logic                     wr_enable,
	input  wire logic [`MFB_SRAM_AW-1:0]  rd_addr,
	output logic      [`MFB_SRAM_DW-1:0]  rd_data,
	// CAM user side.
	input  wire logic [`MFB_CAM_DW-1:0]   cam_data,
	input  wire logic [`MFB_CAM_AW-1:0]   cam_addr,
	input  wire logic                     cam_wr_enable,
	input  wire logic                     cam_chip_sel,
	input  wire logic                     cam_wr_dont_care,
	input  wire logic                     cam_mask_load,
	input  wire logic                     cam_mask_enable,
	output logic      [`MFB_CAM_AW-1:0]   cam_index,
	output logic                          cam_match,
	output logic                          cam_multi_match
);
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [`MFB_SYNC_BITS-1:0] pin_raw, s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	assign pin_raw = {cam_local_reset, sram_local_reset, cam_clock_enable,
		read_port_clock_enable, write_port_clock_enable, global_clock_3,
		global_clock_2, global_clock_1, global_clock_0, cam_clock, read_clock,
		write_clock};
	// A pin level is only accepted once the two later stages agree, which filters one-cycle glitches.
	genvar gi;
	generate
		for (gi = 0; gi < `MFB_SYNC_BITS; gi++) begin : g_sync
			always_comb begin
				filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
			end
			always_ff @(posedge sys_clk) begin
				s1_reg[gi]   <= pin_raw[gi];
				s2_reg[gi]   <= s1_reg[gi];
				s3_reg[gi]   <= s2_reg[gi];
				filt_reg[gi] <= rst_b ? filt_next[gi] : 1'b0;
			end
		end
	endgenerate
	// ------------------------------------------------------------------
	// Clock and enable selection
	// ------------------------------------------------------------------
	function automatic logic pick_clk(clk_src_t src, logic ded, logic [3:0] g, logic inv);
		logic v;
		case (src)
			CLK_GLOBAL_0: v = g[0];
			CLK_GLOBAL_1: v = g[1];
			CLK_GLOBAL_2: v = g[2];
			CLK_GLOBAL_3: v = g[3];
			default:      v = ded;
		endcase
		return v ^ inv;
	endfunction : pick_clk
	function automatic logic pick_ce(ce_src_t src, logic ded, logic [3:0] g, logic inv);
		logic v;
		case (src)
			CE_GLOBAL_1: v = g[1];
			CE_GLOBAL_2: v = g[2];
			default:     v = ded;
		endcase
		return v ^ inv;
	endfunction : pick_ce
	logic [3:0] gclk;
	logic       wclk_lvl, rclk_lvl, cclk_lvl, wce, rce, cce;
	logic       wclk_prev_reg, rclk_prev_reg, cclk_prev_reg;
	logic       w_evt, r_evt, c_evt, sram_rst, cam_rst;
	assign gclk     = filt_reg[6:3];
	assign wclk_lvl = pick_clk(wclk_src, filt_reg[0], gclk, wclk_inv); // RULE_06
	assign rclk_lvl = pick_clk(rclk_src, filt_reg[1], gclk, rclk_inv); // RULE_08
	assign cclk_lvl = pick_clk(cclk_src, filt_reg[2], gclk, cclk_inv); // RULE_20
	assign wce      = pick_ce(wce_src, filt_reg[7], gclk, wce_inv); // RULE_07
	assign rce      = pick_ce(rce_src, filt_reg[8], gclk, rce_inv); // RULE_09
	assign cce      = pick_ce(cce_src, filt_reg[9], gclk, cce_inv); // RULE_20
	// Effective resets; the local one may be inverted before the OR.
	assign sram_rst = !rst_b || (filt_reg[10] ^ sram_reset_inv); // RULE_10 RULE_05
	assign cam_rst  = !rst_b || (filt_reg[11] ^ cam_reset_inv); // RULE_21 RULE_19
	// A selected clock acts on its rising edge, seen as a one-cycle event.
	assign w_evt = wclk_lvl && !wclk_prev_reg && wce && !cam_mode;
	assign r_evt = rclk_lvl && !rclk_prev_reg && rce && !cam_mode;
	assign c_evt = cclk_lvl && !cclk_prev_reg && cce && cam_mode; // RULE_19
	// Previous levels track through reset, so an inverted idle level never looks like an edge.
	always_ff @(posedge sys_clk) begin
		wclk_prev_reg <= wclk_lvl;
		rclk_prev_reg <= rclk_lvl;
		cclk_prev_reg <= cclk_lvl;
	end
	// ------------------------------------------------------------------
	// Dual-port memory
	// ------------------------------------------------------------------
	logic [`MFB_SRAM_DW-1:0] sram_mem [`MFB_SRAM_WORDS]; // RULE_01
	logic [`MFB_SRAM_AW-1:0] wr_addr_reg, wr_addr_next, rd_addr_reg, rd_addr_next, ra;
	logic [`MFB_SRAM_DW-1:0] wr_data_reg, wr_data_next, rd_data_next, rd_word;
	logic                    wr_cs_reg, wr_cs_next, wr_we_reg, wr_we_next;
	logic                    w_go_reg, w_go_next;
	// Lane position of an address at the chosen width: word index, bit offset, lane mask.
	function automatic logic [8:0] word_of(logic [13:0] a, width_t k);
		logic [13:0] s;
		s = a >> (3'h5 - 3'(k));
		return s[8:0];
	endfunction : word_of
	function automatic logic [4:0] off_of(logic [13:0] a, width_t k);
		logic [13:0] s;
		s = a << 3'(k);
		return s[4:0];
	endfunction : off_of
	function automatic logic [31:0] lane_of(width_t k);
		logic [32:0] m;
		m = (33'h1 << (6'h1 << 3'(k))) - 33'h1;
		return m[31:0];
	endfunction : lane_of
	// Write inputs are always captured on the write edge; the array write follows one cycle later.
	always_comb begin
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		wr_cs_next   = wr_cs_reg;
		wr_we_next   = wr_we_reg;
		w_go_next    = 1'b0;
		if (sram_rst) begin
			wr_addr_next = '0;
			wr_data_next = '0;
			wr_cs_next   = 1'b0;
			wr_we_next   = 1'b0;
		end else if (w_evt) begin // RULE_03
			wr_addr_next = wr_addr;
			wr_data_next = wr_data;
			wr_cs_next   = wr_chip_sel;
			wr_we_next   = wr_enable;
			w_go_next    = 1'b1;
		end
	end
	// The array itself is never reset, so contents survive any reset.
	always_ff @(posedge sys_clk) begin
		wr_addr_reg <= wr_addr_next;
		wr_data_reg <= wr_data_next;
		wr_cs_reg   <= wr_cs_next;
		wr_we_reg   <= wr_we_next;
		w_go_reg    <= w_go_next;
		if (w_go_reg && wr_cs_reg && wr_we_reg && !sram_rst) begin // RULE_02 RULE_23
			sram_mem[word_of(wr_addr_reg, width_sel)] <=
				(sram_mem[word_of(wr_addr_reg, width_sel)]
				& ~(lane_of(width_sel) << off_of(wr_addr_reg, width_sel)))
				| ((wr_data_reg & lane_of(width_sel)) << off_of(wr_addr_reg, width_sel));
		end
	end
	// Read path; pass-through mode still ends in the output flop, so it lags one system cycle.
	assign ra      = rd_addr_registered ? rd_addr_reg : rd_addr; // RULE_04
	assign rd_word = (sram_mem[word_of(ra, width_sel)] >> off_of(ra, width_sel))
		& lane_of(width_sel); // RULE_02
	always_comb begin
		rd_addr_next = rd_addr_reg;
		rd_data_next = rd_data;
		if (sram_rst) begin // RULE_05
			rd_addr_next = '0;
			rd_data_next = `MFB_RD_DATA_RST;
		end else begin
			if (r_evt) begin
				rd_addr_next = rd_addr;
			end
			if (r_evt || !rd_data_registered) begin // RULE_04
				rd_data_next = rd_word;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		rd_addr_reg <= rd_addr_next;
		rd_data     <= rd_data_next;
	end
	// ------------------------------------------------------------------
	// Ternary CAM
	// ------------------------------------------------------------------
	logic [`MFB_CAM_DW-1:0] cam_val [`MFB_CAM_ENTRIES]; // RULE_11
	logic [`MFB_CAM_DW-1:0] cam_dc  [`MFB_CAM_ENTRIES];
	logic [`MFB_CAM_DW-1:0] cdata_reg, cdata_next, mask_reg, mask_next, eff_mask, old_val_reg;
	logic [`MFB_CAM_AW-1:0] caddr_reg, caddr_next, idx_next;
	logic                   cwe_reg, cwe_next, ccs_reg, ccs_next, cwdc_reg, cwdc_next;
	logic                   cml_reg, cml_next, c_go_reg, c_go_next, cam_wr_go;
	logic                   match_next, multi_next;
	logic [`MFB_CAM_ENTRIES-1:0] hit_vec;
	// Mask enable is read straight from its input; the user keeps it steady around the edge.
	assign eff_mask  = cam_mask_enable ? mask_reg : '0; // RULE_18
	assign cam_wr_go = c_go_reg && ccs_reg && cwe_reg && !cam_rst;
	always_comb begin
		cdata_next = cdata_reg;
		caddr_next = caddr_reg;
		cwe_next   = cwe_reg;
		ccs_next   = ccs_reg;
		cwdc_next  = cwdc_reg;
		cml_next   = cml_reg;
		c_go_next  = 1'b0;
		mask_next  = (c_go_reg && ccs_reg && cml_reg) ? cdata_reg : mask_reg;
		if (cam_rst) begin // RULE_23
			cdata_next = '0;
			caddr_next = '0;
			cwe_next   = 1'b0;
			ccs_next   = 1'b0;
			cwdc_next  = 1'b0;
			cml_next   = 1'b0;
			mask_next  = '0;
		end else if (c_evt) begin // RULE_17
			cdata_next = cam_data;
			caddr_next = cam_addr;
			cwe_next   = cam_wr_enable;
			ccs_next   = cam_chip_sel;
			cwdc_next  = cam_wr_dont_care;
			cml_next   = cam_mask_load;
			c_go_next  = 1'b1;
		end
	end
	// Update: masked bits keep their state; a don't-care write sets wildcard bits instead.
	always_ff @(posedge sys_clk) begin
		cdata_reg   <= cdata_next;
		caddr_reg   <= caddr_next;
		cwe_reg     <= cwe_next;
		ccs_reg     <= ccs_next;
		cwdc_reg    <= cwdc_next;
		cml_reg     <= cml_next;
		c_go_reg    <= c_go_next;
		mask_reg    <= mask_next;
		old_val_reg <= cam_val[caddr_reg];
		if (cam_wr_go && !cml_reg) begin // RULE_12
			if (cwdc_reg) begin // RULE_16
				cam_dc[caddr_reg] <= cam_dc[caddr_reg] | ~eff_mask;
			end else begin
				cam_val[caddr_reg] <= (cam_val[caddr_reg] & eff_mask)
					| (cdata_reg & ~eff_mask); // RULE_14
				cam_dc[caddr_reg]  <= cam_dc[caddr_reg] & eff_mask;
			end
		end
	end
	// Every entry compares in parallel; wildcards and masked positions never miss.
	generate
		for (gi = 0; gi < `MFB_CAM_ENTRIES; gi++) begin : g_cmp
			assign hit_vec[gi] = ~|((cam_val[gi] ^ cdata_reg) & ~cam_dc[gi] & ~eff_mask); // RULE_15
		end
	endgenerate
	// Lowest hit wins; a second hit anywhere raises the multiple flag.
	always_comb begin
		idx_next   = cam_index;
		match_next = cam_match;
		multi_next = cam_multi_match;
		if (cam_rst) begin // RULE_21
			idx_next   = `MFB_CAM_IDX_RST;
			match_next = 1'b0;
			multi_next = 1'b0;
		end else if (c_go_reg || !cam_out_registered) begin // RULE_17 RULE_19
			idx_next = `MFB_CAM_IDX_RST;
			for (int i = `MFB_CAM_ENTRIES - 1; i >= 0; i--) begin
				if (hit_vec[i]) begin
					idx_next = 7'(i); // RULE_13
				end
			end
			match_next = |hit_vec; // RULE_22
			multi_next = |(hit_vec & (hit_vec - 128'h1)); // RULE_13
		end
	end
	always_ff @(posedge sys_clk) begin
		cam_index       <= idx_next;
		cam_match       <= match_next;
		cam_multi_match <= multi_next;
	end
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wr_capture_a: assert property (w_evt && !sram_rst |=> wr_addr_reg == $past(wr_addr)
		&& wr_data_reg == $past(wr_data)) else $error("write inputs not captured"); // RULE_03
	rd_pass_a: assert property (!rd_data_registered && !rd_addr_registered && !sram_rst
		|=> rd_data === $past(rd_word)) else $error("pass-through read lags"); // RULE_04
	sram_reset_a: assert property (sram_rst |=> rd_data == 32'h0 && rd_addr_reg == '0)
		else $error("read side not reset"); // RULE_05
	multi_flag_a: assert property (cam_multi_match |-> cam_match)
		else $error("multi-match without match"); // RULE_13
	no_hit_a: assert property (!cam_out_registered && !cam_rst && hit_vec == '0
		|=> !cam_match && !cam_multi_match) else $error("flags set without hit"); // RULE_22
	cam_reset_a: assert property (cam_rst |=> !cam_match && !cam_multi_match
		&& cam_index == 7'h0) else $error("cam outputs not reset"); // RULE_21
	cam_update_a: assert property (cam_wr_go && !cml_reg && !cwdc_reg && !cam_mask_enable
		|=> cam_val[$past(caddr_reg)] == $past(cdata_reg)) else $error("entry not written"); // RULE_12
	mask_keep_a: assert property (cam_wr_go && !cml_reg && cam_mask_enable
		|=> ((cam_val[$past(caddr_reg)] ^ old_val_reg) & $past(mask_reg)) == '0)
		else $error("masked bit changed"); // RULE_14
	out_hold_a: assert property (cam_out_registered && !c_go_reg && !cam_rst
		|=> cam_index === $past(cam_index) && cam_match === $past(cam_match))
		else $error("output moved off edge"); // RULE_19
	multi_hit_c: cover property (cam_multi_match);
	sram_write_c: cover property (w_go_reg && wr_cs_reg && wr_we_reg);
	reg_read_c: cover property (r_evt && rd_data_registered ##1 rd_data != 32'h0);
	masked_cmp_c: cover property (cam_mask_enable && cam_match);
endmodule : multi_function_block

/* testbench/fabric_pulser.sv */
// Partner model: fabric logic that gives one clock pin a single pulse per request.
`timescale 1ns/100ps
module fabric_pulser (
	// Clock, reset and request.
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] pin_sel,
	input  wire logic       go,
	// Clock pins and status.
	output logic      [6:0] pins,
	output logic            busy
);
	logic [3:0] count_reg;

	// ------------------------------------------------------------------
	// Pulse generator
	// ------------------------------------------------------------------
	// High 4 and low 8 cycles: past the 3-cycle pin filter on both levels,
	// so an inverted source also sees exactly one rising level per pulse.
	// Pins stand still at 0 between pulses.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			{pins, busy, count_reg} <= '0;
		end else if (!busy && go) begin
			busy <= 1'b1;
			count_reg <= 4'h0;
			pins[pin_sel] <= 1'b1;
		end else if (busy) begin
			count_reg <= count_reg + 4'h1;
			if (count_reg == 4'h3) pins <= 7'h00;
			if (count_reg == 4'hb) busy <= 1'b0;
		end
	end
endmodule : fabric_pulser

/* testbench/multi_function_block_bench.sv */
// Self-checking bench for the memory block in dual-port and CAM modes.
`timescale 1ns/100ps
`include "mfb_map.svh"
module multi_function_block_bench import mfb_pkg::*; ();
	// ------------------------------------------------------------------
	// Signals and reference state
	// ------------------------------------------------------------------
	logic                       sys_clk, rst_b, cam_mode, go, busy, cam_chk;
	width_t                     width_sel;
	clk_src_t                   wclk_src, rclk_src, cclk_src;
	ce_src_t                    wce_src, rce_src, cce_src;
	logic                       wclk_inv, rclk_inv, cclk_inv, wce_inv, rce_inv, cce_inv;
	logic                       sram_reset_inv, cam_reset_inv, rd_addr_registered;
	logic                       rd_data_registered, cam_out_registered;
	logic                       write_port_clock_enable, read_port_clock_enable;
	logic                       cam_clock_enable, sram_local_reset, cam_local_reset;
	logic [`MFB_SRAM_AW-1:0]    wr_addr, rd_addr, a0, a1;
	logic [`MFB_SRAM_DW-1:0]    wr_data, rd_data;
	logic                       wr_chip_sel, wr_enable, cam_wr_enable, cam_chip_sel;
	logic                       cam_wr_dont_care, cam_mask_load, cam_mask_enable;
	logic                       cam_match, cam_multi_match;
	logic [`MFB_CAM_DW-1:0]     cam_data, cam_mask;
	logic [`MFB_CAM_AW-1:0]     cam_addr, cam_index;
	logic [6:0]                 pins;
	logic [2:0]                 pin_sel;
	logic [`MFB_ARRAY_BITS-1:0] mem_ref;
	logic [`MFB_CAM_DW-1:0]     cam_val [`MFB_CAM_ENTRIES];
	logic [`MFB_CAM_DW-1:0]     cam_care [`MFB_CAM_ENTRIES];
	int                         miscompares, samples_checked;

	multi_function_block i_dut (
		.sys_clk, .rst_b, .cam_mode, .width_sel, .wclk_src, .wclk_inv, .wce_src, .wce_inv,
		.rclk_src, .rclk_inv, .rce_src, .rce_inv, .cclk_src, .cclk_inv, .cce_src, .cce_inv,
		.sram_reset_inv, .cam_reset_inv, .rd_addr_registered, .rd_data_registered,
		.cam_out_registered, .global_clock_0(pins[0]), .global_clock_1(pins[1]),
		.global_clock_2(pins[2]), .global_clock_3(pins[3]), .write_clock(pins[4]),
		.read_clock(pins[5]), .cam_clock(pins[6]), .write_port_clock_enable,
		.read_port_clock_enable, .cam_clock_enable, .sram_local_reset, .cam_local_reset,
		.wr_addr, .wr_data, .wr_chip_sel, .wr_enable, .rd_addr, .rd_data, .cam_data,
		.cam_addr, .cam_wr_enable, .cam_chip_sel, .cam_wr_dont_care, .cam_mask_load,
		.cam_mask_enable, .cam_index, .cam_match, .cam_multi_match
	);

	fabric_pulser i_fabric (.sys_clk, .rst_b, .pin_sel, .go, .pins, .busy);

	// 25 MHz system clock.
	always #20 sys_clk = ~sys_clk;

	// ------------------------------------------------------------------
	// Checks, expectations and drivers
	// ------------------------------------------------------------------
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic chk_rd(input logic [31:0] exp);
		samples_checked++;
		if (rd_data !== exp) begin
			miscompares++;
			$display("MISMATCH %0t read data %h expected %h", $time, rd_data, exp);
		end
	endtask : chk_rd

	task automatic chk_cam(input logic [6:0] ei, input logic em, input logic emm);
		samples_checked++;
		if ({cam_index, cam_match, cam_multi_match} !== {ei, em, emm}) begin
			miscompares++;
			$display("MISMATCH %0t cam %h %b %b expected %h %b %b", $time, cam_index,
				cam_match, cam_multi_match, ei, em, emm);
		end
	endtask : chk_cam

	// Word seen at the read port: the addressed bits, zero above the width.
	function automatic logic [31:0] ref_word(input logic [13:0] a);
		int w;
		ref_word = 32'h0;
		w = 1 << int'(width_sel);
		for (int b = 0; b < w; b++) ref_word[b] = mem_ref[int'(a) * w + b];
	endfunction : ref_word

	// One pulse on the pin behind a clock source; the wait is bounded.
	task automatic pulse(input clk_src_t src, input logic [2:0] ded);
		int n;
		pin_sel = (src == CLK_DEDICATED) ? ded : 3'(src) - 3'h1;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		for (n = 0; busy && n < 40; n++) @(negedge sys_clk);
		if (busy) begin
			miscompares++;
			end_of_test();
		end
		repeat (2) @(negedge sys_clk);
	endtask : pulse

	task automatic sram_wr(input logic [13:0] a, input logic [31:0] d, input logic cs, we);
		int w;
		w = 1 << int'(width_sel);
		{wr_addr, wr_data, wr_chip_sel, wr_enable} = {a, d, cs, we};
		pulse(wclk_src, 3'h4);
		if (cs && we && (write_port_clock_enable ^ wce_inv) && !cam_mode)
			for (int b = 0; b < w; b++) mem_ref[int'(a) * w + b] = d[b];
		wr_chip_sel = 1'b0;
	endtask : sram_wr

	task automatic sram_rd(input logic [13:0] a);
		rd_addr = a;
		if (rd_data_registered) pulse(rclk_src, 3'h5);
		else repeat (3) @(negedge sys_clk);
		chk_rd(ref_word(a));
	endtask : sram_rd

	// Every CAM event compares against the contents before any write it makes.
	task automatic cam_op(input logic [47:0] d, input logic [6:0] a,
		input logic we, cs, dc, ld, men);
		logic [6:0]  ei;
		logic        em, emm;
		logic [47:0] ign;
		ign = men ? cam_mask : 48'h0;
		{ei, em, emm} = '0;
		for (int i = 127; i >= 0; i--)
			if (&(~cam_care[i] | ign | ~(cam_val[i] ^ d))) {emm, em, ei} = {em, 1'b1, 7'(i)};
		{cam_data, cam_addr, cam_wr_enable, cam_chip_sel} = {d, a, we, cs};
		{cam_wr_dont_care, cam_mask_load, cam_mask_enable} = {dc, ld, men};
		pulse(cclk_src, 3'h6);
		if (cam_chk) chk_cam(ei, em, emm);
		if (cs && ld) cam_mask = d;
		else if (cs && we) begin
			cam_care[a] = dc ? (cam_care[a] & ign) : (cam_care[a] | ~ign);
			if (!dc) cam_val[a] = (cam_val[a] & ign) | (d & ~ign);
		end
		{cam_chip_sel, cam_mask_enable} = 2'b00;
	endtask : cam_op

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{sys_clk, rst_b, cam_mode, go, cam_chk, pin_sel, miscompares, samples_checked} = '0;
		{rd_addr_registered, rd_data_registered, cam_out_registered} = 3'b001;
		{wr_addr, rd_addr, wr_data, wr_chip_sel, wr_enable, cam_mask} = '0;
		{cam_data, cam_addr, cam_wr_enable, cam_chip_sel} = '0;
		{cam_wr_dont_care, cam_mask_load, cam_mask_enable} = '0;
		{wce_src, rce_src, cce_src} = {CE_DEDICATED, CE_DEDICATED, CE_DEDICATED};
		width_sel = WIDTH_1;
		void'($urandom(60056));
		wclk_src = clk_src_t'($urandom_range(4, 0));
		rclk_src = clk_src_t'($urandom_range(4, 0));
		cclk_src = clk_src_t'($urandom_range(4, 0));
		{wclk_inv, rclk_inv, cclk_inv, wce_inv, rce_inv, cce_inv} = 6'($urandom);
		{sram_reset_inv, cam_reset_inv} = 2'($urandom);
		{write_port_clock_enable, read_port_clock_enable} = {~wce_inv, ~rce_inv};
		{cam_clock_enable, sram_local_reset, cam_local_reset} =
			{~cce_inv, sram_reset_inv, cam_reset_inv};
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (6) @(negedge sys_clk);
		// Back-to-back writes and reads at every word width, then refused writes.
		for (int w = 0; w < 6; w++) begin
			width_sel = width_t'(w);
			repeat (4) begin
				a0 = 14'($urandom_range((16384 >> w) - 1, 0));
				a1 = 14'($urandom_range((16384 >> w) - 1, 0));
				sram_wr(a0, $urandom, 1'b1, 1'b1);
				sram_wr(a1, $urandom, 1'b1, 1'b1);
				sram_rd(a0);
				sram_rd(a1);
			end
			sram_wr(a0, $urandom, 1'b0, 1'b1);
			sram_wr(a0, $urandom, 1'b1, 1'b0);
			sram_rd(a0);
		end
		write_port_clock_enable = ~write_port_clock_enable;
		sram_wr(a0, ~ref_word(a0), 1'b1, 1'b1);
		write_port_clock_enable = ~write_port_clock_enable;
		cam_mode = 1'b1;
		sram_wr(a0, ~ref_word(a0), 1'b1, 1'b1);
		cam_mode = 1'b0;
		sram_rd(a0);
		// Registered read data holds between read events.
		rd_data_registered = 1'b1;
		sram_rd(a0);
		rd_addr = a1;
		repeat (4) @(negedge sys_clk);
		chk_rd(ref_word(a0));
		read_port_clock_enable = ~read_port_clock_enable;
		pulse(rclk_src, 3'h5);
		chk_rd(ref_word(a0));
		read_port_clock_enable = ~read_port_clock_enable;
		sram_local_reset = ~sram_local_reset;
		repeat (6) @(negedge sys_clk);
		chk_rd(32'h0);
		sram_local_reset = ~sram_local_reset;
		repeat (6) @(negedge sys_clk);
		sram_rd(a1);
		// Registered address: each read event shows the address taken at the one before.
		rd_addr_registered = 1'b1;
		rd_addr = a0;
		pulse(rclk_src, 3'h5);
		rd_addr = a1;
		pulse(rclk_src, 3'h5);
		chk_rd(ref_word(a0));
		// CAM: fill every entry, then compare, update, mask and wildcard.
		cam_mode = 1'b1;
		for (int i = 0; i < 128; i++) cam_op({$urandom, 9'($urandom), 7'(i)}, 7'(i),
			1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_chk = 1'b1;
		repeat (20) cam_op(($urandom & 1) ? cam_val[$urandom_range(127, 0)] :
			{$urandom, 16'($urandom)}, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op(cam_val[5], 7'd90, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op(cam_val[5], 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op(cam_val[7], 7'd6, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		cam_op(cam_val[6], 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op(48'h7f, 7'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		cam_op({cam_val[10][47:7], 7'h55}, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		cam_op({$urandom, 16'($urandom)}, 7'd20, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		cam_op(cam_val[20], 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op(48'h0, 7'd30, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		cam_op({$urandom, 16'($urandom) & 16'hff80 | 16'h001e}, 7'h00,
			1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		// Local CAM reset clears outputs and mask but keeps the entries.
		cam_local_reset = ~cam_local_reset;
		repeat (6) @(negedge sys_clk);
		chk_cam(7'h00, 1'b0, 1'b0);
		cam_local_reset = ~cam_local_reset;
		cam_mask = 48'h0;
		repeat (6) @(negedge sys_clk);
		cam_op(cam_val[40], 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		// Pass-through outputs; the cleared mask must no longer hide the low bits.
		cam_out_registered = 1'b0;
		cam_op(cam_val[40], 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		cam_op({cam_val[40][47:7], 7'h55}, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		end_of_test();
	end
endmodule : multi_function_block_bench
